// ### rtl/cam_cmd_host.sv
// Host end: issues one instruction word and, for direct forms, its address
`timescale 1ns/100ps
module cam_cmd_host
  import cam_cmd_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  cam_cmd_if.host link,
  input wire logic req_i,
  input wire logic [cam_cmd_pkg::INSTR_W-1:0] op_i,
  input wire logic [cam_cmd_pkg::ADDR_W-1:0] addr_i,
  output logic ready_o,
  output logic done_o
);
  import cam_cmd_pkg::*;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_ADDR = 2'b01,
    H_WAIT = 2'b10
  } hstate_type;

  hstate_type state_r;
  logic cmd_valid_r, addr_valid_r, ready_r, done_r;
  logic [15:0] cmd_r;
  logic [ADDR_W-1:0] addr_r;

  // ----------------------------------------
  // Issue
  // ----------------------------------------
  wire direct = (op_i[15:8] == CLS_MOVE_DIRECT) || (op_i == OP_MASK_ONE_DIRECT);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_r <= H_IDLE;
      cmd_valid_r <= 1'b0;
      addr_valid_r <= 1'b0;
      cmd_r <= '0;
      addr_r <= '0;
      ready_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      cmd_valid_r <= 1'b0;
      addr_valid_r <= 1'b0;
      done_r <= 1'b0;
      unique case (state_r)
        H_IDLE: begin
          ready_r <= !req_i;
          if (req_i && ready_r && !link.busy) begin
            cmd_valid_r <= 1'b1;
            cmd_r <= op_i;
            addr_r <= addr_i;
            ready_r <= 1'b0;
            state_r <= direct ? H_ADDR : H_WAIT;
          end
        end
        H_ADDR: begin
          addr_valid_r <= 1'b1;
          state_r <= H_WAIT;
        end
        H_WAIT: begin
          if (link.done) begin
            done_r <= 1'b1;
            ready_r <= 1'b1;
            state_r <= H_IDLE;
          end
        end
        default: state_r <= H_IDLE;
      endcase
    end
  end

  assign link.cmd_valid = cmd_valid_r;
  assign link.cmd_word = cmd_r;
  assign link.addr_valid = addr_valid_r;
  assign link.addr_word = addr_r;
  assign ready_o = ready_r;
  assign done_o = done_r;
endmodule

// ### rtl/cam_cmd_if.sv
// Instruction link between host and decoder
`timescale 1ns/100ps
interface cam_cmd_if;
  logic cmd_valid;
  logic [15:0] cmd_word;
  logic addr_valid;
  logic [9:0] addr_word;
  logic busy;
  logic done;
  modport host (output cmd_valid, output cmd_word, output addr_valid, output addr_word, input busy, input done);
  modport device (input cmd_valid, input cmd_word, input addr_valid, input addr_word, output busy, output done);
endinterface

// ### rtl/cam_cmd_pkg.sv
// Opcodes, field positions and sizes for the data-move and compare command decoder
package cam_cmd_pkg;
  localparam int WORD_W = 64;
  localparam int ADDR_W = 10;
  localparam int DEPTH = 1024;
  localparam int INSTR_W = 16;
  // Opcode classes (upper byte)
  localparam logic [7:0] CLS_MOVE = 8'h03;
  localparam logic [7:0] CLS_MOVE_DIRECT = 8'h0B;
  localparam logic [7:0] CLS_MOVE_DIRECT_ALT = 8'h08;
  localparam logic [7:0] CLS_COMPARE = 8'h05;
  localparam logic [7:0] CLS_SPECIAL = 8'h07;
  // Low-byte fields of move opcodes
  localparam int MASK_SEL_HI = 7;
  localparam int MASK_SEL_LO = 6;
  localparam int DEST_HI = 5;
  localparam int DEST_LO = 2;
  localparam int SRC_HI = 1;
  localparam int SRC_LO = 0;
  // Destination / mask select codes
  localparam logic [3:0] DST_COMP = 4'h0;
  localparam logic [3:0] DST_COMP_MEM = 4'h1;
  localparam logic [3:0] DST_MASK_ONE = 4'h2;
  localparam logic [3:0] DST_MASK_ONE_MEM = 4'h3;
  localparam logic [3:0] DST_MASK_TWO = 4'h4;
  localparam logic [3:0] DST_MASK_TWO_MEM = 4'h5;
  localparam logic [3:0] DST_MEM_PTR = 4'h8;
  localparam logic [3:0] DST_MEM_PTR_V = 4'h9;
  localparam logic [3:0] DST_MEM_MATCH = 4'hA;
  localparam logic [3:0] DST_MEM_MATCH_V = 4'hB;
  localparam logic [3:0] DST_MEM_FREE = 4'hC;
  localparam logic [3:0] DST_MEM_FREE_V = 4'hD;
  localparam logic [1:0] MSEL_NONE = 2'h0;
  localparam logic [1:0] MSEL_ONE = 2'h1;
  localparam logic [1:0] MSEL_TWO = 2'h2;
  // Explicit opcodes
  localparam logic [15:0] OP_SET_FULL = 16'h0700;
  localparam logic [15:0] OP_FREE_MASKED_TWO = 16'h0380;
  localparam logic [15:0] OP_FREE_MASKED_TWO_V = 16'h0384;
  localparam logic [15:0] OP_MASK_ONE_DIRECT = 16'h080C;
  // Validity states
  typedef enum logic [1:0] {
    VAL_VALID = 2'b00,
    VAL_EMPTY = 2'b01,
    VAL_SKIP = 2'b10,
    VAL_RANDOM = 2'b11
  } validity_type;
  localparam logic [15:0] OP_SEARCH_BASE = 16'h0504;
  localparam logic [1:0] SEARCH_SEL_HI = 2'd1;
endpackage

// ### rtl/cam_move_compare_decoder.sv
// Device end: decodes move, compare and special instructions over a 1K x 64 array
//
// Contract
// - 0300 none; 0301/0302 copy mask into comparand
// - Comparand from memory at address pointer
// - Comparand from memory at direct address
// - Comparand from highest priority match word
// - Mask one loads; 0309 does nothing
// - Mask two loads; 0312 does nothing
// - Write at pointer, validity unchanged
// - Write at pointer, mark valid
// - Write direct address, validity unchanged
// - Write direct address, mark valid
// - Write highest match, validity unchanged
// - Write highest match, mark valid
// - Write next free, validity unchanged
// - Write next free, mark valid
// - Compare restricted to one validity state
// - 0700 forces full flag asserted
`timescale 1ns/100ps
module cam_move_compare_decoder
  import cam_cmd_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  cam_cmd_if.device link,
  input wire logic [cam_cmd_pkg::ADDR_W-1:0] ptr_load_i,
  input wire logic ptr_load_en_i,
  output logic [cam_cmd_pkg::WORD_W-1:0] comparand_o,
  output logic match_o,
  output logic [cam_cmd_pkg::ADDR_W-1:0] match_addr_o,
  output logic full_o,
  output logic illegal_o
);
  import cam_cmd_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_EXEC = 2'b10
  } state_type;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [WORD_W-1:0] mem_r [DEPTH];
  validity_type val_r [DEPTH];
  logic [WORD_W-1:0] comparand_register_r;
  logic [WORD_W-1:0] mask_register_one_r;
  logic [WORD_W-1:0] mask_register_two_r;
  logic [ADDR_W-1:0] address_pointer_r;
  logic [ADDR_W-1:0] direct_addr_r;
  logic [15:0] op_r;
  state_type state_r;
  logic busy_r, done_r, full_r, force_full_r, match_r, illegal_r;
  logic [ADDR_W-1:0] match_loc_r;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire [7:0] cls = op_r[15:8];
  wire [1:0] msel = op_r[MASK_SEL_HI:MASK_SEL_LO];
  wire [3:0] dst = op_r[DEST_HI:DEST_LO];
  wire [1:0] src = op_r[SRC_HI:SRC_LO];
  wire is_alt_mask_one = (op_r == OP_MASK_ONE_DIRECT);
  wire is_free_odd = (op_r == OP_FREE_MASKED_TWO) || (op_r == OP_FREE_MASKED_TWO_V);
  wire [7:0] in_cls = link.cmd_word[15:8];
  wire needs_addr = (in_cls == CLS_MOVE_DIRECT) || (link.cmd_word == OP_MASK_ONE_DIRECT);
  wire is_move = (cls == CLS_MOVE) || (cls == CLS_MOVE_DIRECT) || is_alt_mask_one;
  wire direct = (cls == CLS_MOVE_DIRECT) || is_alt_mask_one;
  wire [3:0] dst_eff = is_alt_mask_one ? DST_MASK_ONE_MEM :
    (is_free_odd ? (op_r[2] ? DST_MEM_FREE_V : DST_MEM_FREE) : dst);
  wire [1:0] msel_eff = is_free_odd ? MSEL_TWO : msel;
  wire [1:0] src_eff = is_free_odd ? 2'h0 : src;

  // Next free and highest match search
  logic [ADDR_W-1:0] free_addr;
  logic free_found;
  always_comb begin
    free_addr = '0;
    free_found = 1'b0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (val_r[i] == VAL_EMPTY) begin
        free_addr = ADDR_W'(i);
        free_found = 1'b1;
      end
    end
  end

  // Register loads from memory with source code 1 read the match word; memory writes use dst
  wire dst_mem = dst_eff[3];
  wire from_match = (dst_eff == DST_MEM_MATCH) || (dst_eff == DST_MEM_MATCH_V) ||
    (!dst_mem && dst_eff[0] && src_eff == 2'h1);
  wire to_free = (dst_eff == DST_MEM_FREE) || (dst_eff == DST_MEM_FREE_V);
  wire [ADDR_W-1:0] mem_addr = direct ? direct_addr_r : from_match ? match_loc_r :
    to_free ? free_addr : address_pointer_r;
  wire [WORD_W-1:0] mem_word = mem_r[mem_addr];
  wire [WORD_W-1:0] mask_sel = (msel_eff == MSEL_ONE) ? mask_register_one_r :
    (msel_eff == MSEL_TWO) ? mask_register_two_r : {WORD_W{1'b1}};
  wire [WORD_W-1:0] src_word = (src_eff == 2'h1) ? mask_register_one_r :
    (src_eff == 2'h2) ? mask_register_two_r : comparand_register_r;
  wire set_valid = dst_mem && dst_eff[0];
  wire [WORD_W-1:0] mem_new = (mem_word & ~mask_sel) | (src_word & mask_sel);
  wire [WORD_W-1:0] comp_new = (comparand_register_r & ~mask_sel) | (mem_word & mask_sel);
  wire match_needed = from_match && !direct;
  wire exec_ok = !(match_needed && !match_r) && !(to_free && !free_found);
  wire search_go = (cls == CLS_COMPARE) && (op_r[7:2] == OP_SEARCH_BASE[7:2]);
  validity_type search_state;
  assign search_state = validity_type'(op_r[SEARCH_SEL_HI:0]);

  logic hit_any;
  logic [ADDR_W-1:0] hit_addr;
  always_comb begin
    hit_any = 1'b0;
    hit_addr = '0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (val_r[i] == search_state && ((mem_r[i] ^ comparand_register_r) & ~mask_register_one_r) == '0) begin
        hit_any = 1'b1;
        hit_addr = ADDR_W'(i);
      end
    end
  end

  wire any_empty = free_found;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      op_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      direct_addr_r <= '0;
      illegal_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      unique case (state_r)
        ST_IDLE: begin
          if (link.cmd_valid) begin
            op_r <= link.cmd_word;
            busy_r <= 1'b1;
            illegal_r <= 1'b0;
            state_r <= needs_addr ? ST_ADDR : ST_EXEC;
          end
        end
        ST_ADDR: begin
          if (link.addr_valid) begin
            direct_addr_r <= link.addr_word;
            state_r <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
          illegal_r <= is_move ? !exec_ok : !(search_go || op_r == OP_SET_FULL);
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Register transfers
  // ----------------------------------------
  wire run = (state_r == ST_EXEC);
  wire run_mv = run && is_move && exec_ok;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      comparand_register_r <= '0;
      mask_register_one_r <= '0;
      mask_register_two_r <= '0;
      address_pointer_r <= '0;
      match_r <= 1'b0;
      match_loc_r <= '0;
      force_full_r <= 1'b0;
    end else begin
      if (ptr_load_en_i) address_pointer_r <= ptr_load_i;
      if (run_mv && !dst_mem) begin
        unique case (dst_eff)
          DST_COMP: begin
            if (src == 2'h1) comparand_register_r <= mask_register_one_r;
            else if (src == 2'h2) comparand_register_r <= mask_register_two_r;
            else if (src == 2'h0) comparand_register_r <= comparand_register_r;
          end
          DST_COMP_MEM: comparand_register_r <= comp_new;
          DST_MASK_ONE: begin
            if (src == 2'h0) mask_register_one_r <= comparand_register_r;
            else if (src == 2'h2) mask_register_one_r <= mask_register_two_r;
          end
          DST_MASK_ONE_MEM: mask_register_one_r <= mem_word;
          DST_MASK_TWO: begin
            if (src == 2'h0) mask_register_two_r <= comparand_register_r;
            else if (src == 2'h1) mask_register_two_r <= mask_register_one_r;
          end
          DST_MASK_TWO_MEM: mask_register_two_r <= mem_word;
          default: ;
        endcase
      end
      if (run && search_go) begin
        match_r <= hit_any;
        match_loc_r <= hit_addr;
      end
      if (run && op_r == OP_SET_FULL) force_full_r <= 1'b1;
      else if (run && search_go) force_full_r <= 1'b0;
    end
  end

  // Memory writes, comparand load from pointer/direct handled above via mem_addr
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      for (int i = 0; i < DEPTH; i++) val_r[i] <= VAL_EMPTY;
    end else if (run_mv && dst_mem) begin
      mem_r[mem_addr] <= mem_new;
      if (set_valid) val_r[mem_addr] <= VAL_VALID;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      full_r <= 1'b0;
    end else begin
      full_r <= force_full_r || (run && op_r == OP_SET_FULL) || !any_empty;
    end
  end

  assign link.busy = busy_r;
  assign link.done = done_r;
  assign comparand_o = comparand_register_r;
  assign match_o = match_r;
  assign match_addr_o = match_loc_r;
  assign full_o = full_r;
  assign illegal_o = illegal_r;
endmodule

// ### sim/cam_cmd_monitor.sv
// Concurrent checks on the host to decoder instruction link
`timescale 1ns/100ps
module cam_cmd_monitor (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_word,
  input wire logic addr_valid,
  input wire logic [9:0] addr_word,
  input wire logic busy,
  input wire logic done
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  wire logic direct_w;
  wire logic take_w;
  assign direct_w = (cmd_word[15:8] == cam_cmd_pkg::CLS_MOVE_DIRECT) ||
    (cmd_word == cam_cmd_pkg::OP_MASK_ONE_DIRECT);
  assign take_w = cmd_valid && !busy;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_short_done_timing:
    assert property (take_w && !direct_w |=> busy ##1 (done && !busy)) else $error("short op timing wrong");
  chk_direct_done_timing:
    assert property (take_w && direct_w |=> busy [*2] ##1 (done && !busy)) else $error("direct op timing wrong");
  chk_addr_follows_cmd:
    assert property (take_w && direct_w |=> addr_valid) else $error("address word missing");
  chk_addr_paired_direct:
    assert property (addr_valid |-> $past(cmd_valid) && $past(direct_w)) else $error("stray address word");
  chk_addr_to_done:
    assert property (addr_valid |-> ##2 done) else $error("done not two cycles after address");
  chk_done_single_pulse:
    assert property (done |=> !done) else $error("done longer than one cycle");
  chk_cmd_single_pulse:
    assert property (cmd_valid |=> !cmd_valid) else $error("command strobe too long");
  chk_one_outstanding:
    assert property (cmd_valid |-> !busy) else $error("command while busy");
  chk_busy_has_cause:
    assert property ($rose(busy) |-> $past(cmd_valid)) else $error("busy without command");
  // ----------------------------------------
  // Coverage
  // ----------------------------------------
  cov_direct: cover property (take_w && direct_w);
  cov_short: cover property (take_w && !direct_w);
  cov_done: cover property (done);
endmodule

// ### sim/cam_move_compare_decoder_bench.sv
// Self-checking bench for the host and decoder ends
`timescale 1ns/100ps
module cam_move_compare_decoder_bench;
  import cam_cmd_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic req_i = 1'b0;
  logic [15:0] op_i = 16'h0000;
  logic [9:0] addr_i = 10'h000;
  logic [9:0] ptr_load_i = 10'h000;
  logic ptr_load_en_i = 1'b0;
  logic ready_o;
  logic done_o;
  logic match_o;
  logic full_o;
  logic illegal_o;
  logic [63:0] comparand_o;
  logic [9:0] match_addr_o;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [15:0] ops [60] = '{16'h0300, 16'h0301, 16'h0302, 16'h0304, 16'h0344, 16'h0B04, 16'h0B44, 16'h0B84,
    16'h0305, 16'h0345, 16'h0385, 16'h0308, 16'h0309, 16'h030A, 16'h030C, 16'h080C, 16'h030D, 16'h0310,
    16'h0311, 16'h0312, 16'h0314, 16'h0B14, 16'h0315, 16'h0320, 16'h0360, 16'h03A0, 16'h0321, 16'h0322,
    16'h0324, 16'h0364, 16'h03A4, 16'h0325, 16'h0326, 16'h0B20, 16'h0B60, 16'h0BA0, 16'h0B21, 16'h0B22,
    16'h0B24, 16'h0B64, 16'h0BA4, 16'h0B25, 16'h0B26, 16'h0328, 16'h0368, 16'h03A8, 16'h0329, 16'h032A,
    16'h032C, 16'h036C, 16'h03AC, 16'h032D, 16'h032E, 16'h0330, 16'h0370, 16'h0380, 16'h0331, 16'h0332,
    16'h0334, 16'h0374};
  always #25 clk_sys_i = ~clk_sys_i;
  // ----------------------------------------
  // Both ends and the checker
  // ----------------------------------------
  cam_cmd_if cam_cmd_if_inst ();
  cam_cmd_host cam_cmd_host_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(cam_cmd_if_inst), .req_i(req_i),
    .op_i(op_i), .addr_i(addr_i), .ready_o(ready_o), .done_o(done_o));
  cam_move_compare_decoder cam_move_compare_decoder_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .link(cam_cmd_if_inst), .ptr_load_i(ptr_load_i), .ptr_load_en_i(ptr_load_en_i), .comparand_o(comparand_o),
    .match_o(match_o), .match_addr_o(match_addr_o), .full_o(full_o), .illegal_o(illegal_o));
  cam_cmd_monitor cam_cmd_monitor_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .cmd_valid(cam_cmd_if_inst.cmd_valid), .cmd_word(cam_cmd_if_inst.cmd_word),
    .addr_valid(cam_cmd_if_inst.addr_valid), .addr_word(cam_cmd_if_inst.addr_word),
    .busy(cam_cmd_if_inst.busy), .done(cam_cmd_if_inst.done));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task complete_run;
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task run_op(input logic [15:0] op, input logic [9:0] addr);
    int i;
    for (i = 0; i < 40 && ready_o !== 1'b1; i++) @(negedge clk_sys_i);
    @(negedge clk_sys_i);
    req_i = 1'b1;
    op_i = op;
    addr_i = addr;
    for (i = 0; i < 40 && done_o !== 1'b1; i++) begin
      @(negedge clk_sys_i);
      if (ready_o !== 1'b1) req_i = 1'b0;
    end
    check(done_o, 64'h1);
  endtask
  task set_ptr(input logic [9:0] p);
    @(negedge clk_sys_i);
    ptr_load_i = p;
    ptr_load_en_i = 1'b1;
    @(negedge clk_sys_i);
    ptr_load_en_i = 1'b0;
  endtask
  // ----------------------------------------
  // Timeout
  // ----------------------------------------
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 4000) begin
      bad_count++;
      complete_run();
    end
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (20) @(negedge clk_sys_i);
    rst_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    check(comparand_o, 64'h0);
    check(full_o, 64'h0);
    check(ready_o, 64'h1);
    $display("Test reset done");
    run_op(16'h0305, 10'h000);
    check(illegal_o, 64'h1);
    check(comparand_o, 64'h0);
    $display("Test refused match done");
    set_ptr(10'h007);
    run_op(16'h0324, 10'h000);
    check(illegal_o, 64'h0);
    run_op(16'h0506, 10'h000);
    check(match_o, 64'h0);
    run_op(16'h0507, 10'h000);
    check(match_o, 64'h0);
    run_op(16'h0504, 10'h000);
    check(match_o, 64'h1);
    check(match_addr_o, 64'h7);
    $display("Test compare done");
    run_op(16'h0700, 10'h000);
    check(full_o, 64'h1);
    run_op(16'h0504, 10'h000);
    check(full_o, 64'h0);
    $display("Test full flag done");
    run_op(16'h0B24, 10'h3FF);
    check(illegal_o, 64'h0);
    run_op(16'h0B04, 10'h3FF);
    check(comparand_o, 64'h0);
    check(illegal_o, 64'h0);
    $display("Test direct done");
    run_op(16'h0506, 10'h000);
    check(match_o, 64'h0);
    run_op(16'h0311, 10'h000);
    check(illegal_o, 64'h0);
    run_op(16'h0309, 10'h000);
    check(illegal_o, 64'h0);
    set_ptr(10'h005);
    run_op(16'h0325, 10'h000);
    check(illegal_o, 64'h0);
    run_op(16'h0504, 10'h000);
    check(match_addr_o, 64'h5);
    run_op(16'h0331, 10'h000);
    check(illegal_o, 64'h0);
    run_op(16'h0505, 10'h000);
    check(match_o, 64'h1);
    check(match_addr_o, 64'h0);
    $display("Test address select done");
    foreach (ops[k]) begin
      run_op(ops[k], 10'h007);
      check(illegal_o, 64'h0);
      check(comparand_o, 64'h0);
    end
    $display("Test opcode table done");
    complete_run();
  end
endmodule
